// >>> clds_pkg.sv
// Operation
// (RULE1) bits 5,4 show live detect and lock
// (RULE2) lock flag works only with enable bit 1
// (RULE3) lock flag sets on lock rising edge
// (RULE4) lock flag holds until status read
// (RULE5) detect flag works only with enable bit 0
// (RULE6) detect flag sets on any detect change
// (RULE7) disabled flag never sets; both clear on read
package clds_pkg;
  localparam logic [7:0] CLDS_ADDR_STATUS  = 8'h78;
  localparam logic [7:0] CLDS_ADDR_ENABLE  = 8'h79;
  localparam logic [7:0] CLDS_STATUS_RESET = 8'h00;
  localparam logic [7:0] CLDS_ENABLE_RESET = 8'h10;
  localparam int CLDS_BIT_DETECT_STATE = 5;
  localparam int CLDS_BIT_LOCK_STATE   = 4;
  localparam int CLDS_BIT_LOCK_FLAG    = 3;
  localparam int CLDS_BIT_DETECT_FLAG  = 2;
  localparam int CLDS_BIT_EN_LOCK      = 1;
  localparam int CLDS_BIT_EN_DETECT    = 0;

  // register access request from the management port
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } clds_req_t;
endpackage

// >>> clds_status.sv
module clds_status
  import clds_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire clds_req_t  req,
  output logic [7:0]      rdata,
  input  wire logic       signal_detect_in,
  input  wire logic       recovery_lock_in
);

  // strobe aimed at one register of this block
  function automatic logic reg_hit(
    input logic       strobe,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return strobe && (addr == target);
  endfunction

  // low-to-high step between two samples of a level
  function automatic logic level_rose(
    input logic now_level,
    input logic last_level
  );
    return now_level && !last_level;
  endfunction

  // any step between two samples of a level
  function automatic logic level_moved(
    input logic now_level,
    input logic last_level
  );
    return now_level != last_level;
  endfunction

  // status byte: live state on top, sticky flags below, spare bits zero
  function automatic logic [7:0] status_byte(
    input logic det_state,
    input logic lock_state,
    input logic lock_flag,
    input logic det_flag
  );
    logic [7:0] b;
    b                        = 8'h00;
    b[CLDS_BIT_DETECT_STATE] = det_state;
    b[CLDS_BIT_LOCK_STATE]   = lock_state;
    b[CLDS_BIT_LOCK_FLAG]    = lock_flag;
    b[CLDS_BIT_DETECT_FLAG]  = det_flag;
    return b;
  endfunction

  // synchroniser stages for the two live pins
  logic [1:0] det_sync_q,           det_sync_d;
  logic [1:0] lock_sync_q,          lock_sync_d;

  // last synchronised level, for edge detection
  logic       det_prev_q,           det_prev_d;
  logic       lock_prev_q,          lock_prev_d;

  // software-visible state
  logic       lock_gain_flag_q,     lock_gain_flag_d;
  logic       detect_change_flag_q, detect_change_flag_d;
  logic [7:0] enable_q,             enable_d;
  logic [7:0] rdata_q,              rdata_d;

  // decoded strobes and events
  logic       signal_detect_state;
  logic       recovery_lock_state;
  logic       status_rd;
  logic       enable_rd;
  logic       enable_wr;
  logic       lock_gain_evt;
  logic       detect_change_evt;

  // only the second stage feeds logic
  assign signal_detect_state = det_sync_q[1];
  assign recovery_lock_state = lock_sync_q[1];

  // register decode
  assign status_rd = reg_hit(req.rd, req.addr, CLDS_ADDR_STATUS);
  assign enable_rd = reg_hit(req.rd, req.addr, CLDS_ADDR_ENABLE);
  assign enable_wr = reg_hit(req.wr, req.addr, CLDS_ADDR_ENABLE);

  // (RULE2) lock event gating
  // (RULE7) disabled flag stays put
  assign lock_gain_evt = enable_q[CLDS_BIT_EN_LOCK] && level_rose(recovery_lock_state, lock_prev_q);

  // (RULE5) detect event gating
  assign detect_change_evt = enable_q[CLDS_BIT_EN_DETECT] && level_moved(signal_detect_state, det_prev_q);

  // read data leaves from its register
  assign rdata = rdata_q;

  // detect pin synchroniser, next value
  always_comb begin
    det_sync_d = {det_sync_q[0], signal_detect_in};
  end

  // detect pin synchroniser, register
  always_ff @(posedge mclk) begin
    if (rst) begin
      det_sync_q <= 2'h0;
    end else begin
      det_sync_q <= det_sync_d;
    end
  end

  // lock pin synchroniser, next value
  always_comb begin
    lock_sync_d = {lock_sync_q[0], recovery_lock_in};
  end

  // lock pin synchroniser, register
  always_ff @(posedge mclk) begin
    if (rst) begin
      lock_sync_q <= 2'h0;
    end else begin
      lock_sync_q <= lock_sync_d;
    end
  end

  // previous levels, next value
  always_comb begin
    det_prev_d  = signal_detect_state;
    lock_prev_d = recovery_lock_state;
  end

  // previous levels; a pin high at reset release reads as an event
  always_ff @(posedge mclk) begin
    if (rst) begin
      det_prev_q  <= 1'b0;
      lock_prev_q <= 1'b0;
    end else begin
      det_prev_q  <= det_prev_d;
      lock_prev_q <= lock_prev_d;
    end
  end

  // enable register, next value
  always_comb begin
    enable_d = enable_q;
    if (enable_wr) begin
      enable_d = req.wdata;
    end
  end

  // enable register
  always_ff @(posedge mclk) begin
    if (rst) begin
      enable_q <= CLDS_ENABLE_RESET;
    end else begin
      enable_q <= enable_d;
    end
  end

  // lock flag, next value
  always_comb begin
    lock_gain_flag_d = lock_gain_flag_q;
    // (RULE4) cleared only by status read
    if (status_rd) begin
      lock_gain_flag_d = 1'b0;
    end
    // (RULE3) set on new lock; set wins
    if (lock_gain_evt) begin
      lock_gain_flag_d = 1'b1;
    end
  end

  // lock flag
  always_ff @(posedge mclk) begin
    if (rst) begin
      lock_gain_flag_q <= CLDS_STATUS_RESET[CLDS_BIT_LOCK_FLAG];
    end else begin
      lock_gain_flag_q <= lock_gain_flag_d;
    end
  end

  // detect flag, next value
  always_comb begin
    detect_change_flag_d = detect_change_flag_q;
    // (RULE7) clears like lock flag
    if (status_rd) begin
      detect_change_flag_d = 1'b0;
    end
    // (RULE6) set on detect change
    // a change in the read cycle wins over the clear
    if (detect_change_evt) begin
      detect_change_flag_d = 1'b1;
    end
  end

  // detect flag
  always_ff @(posedge mclk) begin
    if (rst) begin
      detect_change_flag_q <= CLDS_STATUS_RESET[CLDS_BIT_DETECT_FLAG];
    end else begin
      detect_change_flag_q <= detect_change_flag_d;
    end
  end

  // read data, next value; held between reads
  always_comb begin
    rdata_d = rdata_q;
    if (req.rd) begin
      rdata_d = 8'h00; // unmapped reads give zero
      // (RULE1) live state bits
      if (status_rd) begin
        rdata_d = status_byte(signal_detect_state, recovery_lock_state,
                              lock_gain_flag_q, detect_change_flag_q);
      end
      if (enable_rd) begin
        rdata_d = enable_q;
      end
    end
  end

  // read data register
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end
endmodule

// >>> clds_status_properties.sv
module clds_status_properties import clds_pkg::*; (
  input logic       mclk,
  input logic       rst,
  input clds_req_t  req,
  input logic [7:0] rdata,
  input logic       signal_detect_in,
  input logic       recovery_lock_in);
  logic [1:0] en_q;
  logic [7:0] en_all_q;
  wire logic rs = req.rd && req.addr == CLDS_ADDR_STATUS;
  wire logic es = req.rd && req.addr == CLDS_ADDR_ENABLE;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // enable bits as last written
  always_ff @(posedge mclk) begin
    if (rst) begin
      en_q     <= CLDS_ENABLE_RESET[1:0];
      en_all_q <= CLDS_ENABLE_RESET;
    end else if (req.wr && req.addr == CLDS_ADDR_ENABLE) begin
      en_q     <= req.wdata[1:0];
      en_all_q <= req.wdata;
    end
  end
  // four cycles without a status read
  sequence s_quiet; (!rs)[*4]; endsequence
  // enabled lock rise on the pin
  sequence s_lock_gain; en_q[1] && $rose(recovery_lock_in); endsequence
  // enabled detect change on the pin
  sequence s_det_move; en_q[0] && $changed(signal_detect_in); endsequence
  property p_set; (en_q[1] && $rose(recovery_lock_in)) ##1 (en_q[1] && !rs)[*4] ##1 rs |=> rdata[3]; endproperty
  a_set: assert property (p_set) else $error("lock flag not set");
  property p_off; (rs && en_q == 2'h0) ##1 (en_q == 2'h0 && !rs)[*4] ##1 rs |=> rdata[3:2] == 2'h0; endproperty
  a_off: assert property (p_off) else $error("flag set while off");
  property p_det; s_det_move ##1 (en_q[0] && !rs)[*4] ##1 rs |=> rdata[2]; endproperty
  a_det: assert property (p_det) else $error("detect flag not set");
  property p_hold; s_lock_gain ##1 (en_q[1] && !rs)[*2] ##1 s_quiet ##1 (!rs)[*3] ##1 rs |=> rdata[3]; endproperty
  a_hold: assert property (p_hold) else $error("lock flag not held");
  property p_live;
    rs |=> rdata[5] == $past(signal_detect_in, 3) && rdata[4] == $past(recovery_lock_in, 3);
  endproperty
  a_live: assert property (p_live) else $error("live state wrong");
  property p_resv; rs |=> rdata[7:6] == 2'h0 && rdata[1:0] == 2'h0; endproperty
  a_resv: assert property (p_resv) else $error("spare status bits set");
  property p_en; es |=> rdata == $past(en_all_q); endproperty
  a_en: assert property (p_en) else $error("enable readback wrong");
endmodule
bind clds_status clds_status_properties u_props (.mclk, .rst, .req, .rdata, .signal_detect_in, .recovery_lock_in);

// >>> clds_status_tb.sv
module clds_status_tb import clds_pkg::*;;
  timeunit 1ns / 100ps;
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic        sd   = 1'b0;
  logic        lk   = 1'b0;
  clds_req_t   req  = '0;
  logic [7:0]  rdata;
  logic [31:0] s    = 32'h9C92;
  logic [7:0]  en_model;
  int          miscompares = 0;
  int          checks_done = 0;
  clds_status u_clds_status (
    .mclk             (mclk),
    .rst              (rst),
    .req              (req),
    .rdata            (rdata),
    .signal_detect_in (sd),
    .recovery_lock_in (lk)
  );
  // clock, 5 ns period
  always #2.5 mclk = ~mclk;
  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    y = y ^ (y << 5);
    return y;
  endfunction
  // expected status byte
  function automatic logic [7:0] exp_status(input logic det, input logic lock, input logic lf, input logic df);
    return {2'h0, det, lock, lf, df, 2'h0};
  endfunction
  // compare seen against expected
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done += 1;
    if (seen !== exp) begin
      miscompares += 1;
      $display("[ERR] %0t %h %h", $time, seen, exp);
    end
  endtask
  // one request for one edge; it stands until the next call
  task automatic acc(input logic rd, input logic wr, input logic [7:0] a, input logic [7:0] v);
    req = '{rd, wr, a, v};
    @(posedge mclk);
    #1;
  endtask
  // idle cycles
  task automatic idle(input int n);
    repeat (n) acc(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    en_model = CLDS_ENABLE_RESET;
    repeat (8) @(posedge mclk);
    #1;
    rst = 1'b0;
    acc(1'b1, 1'b0, CLDS_ADDR_ENABLE, 8'h00);
    check(rdata, en_model);
    acc(1'b0, 1'b1, CLDS_ADDR_STATUS, 8'hFF);
    acc(1'b1, 1'b0, CLDS_ADDR_STATUS, 8'h00);
    check(rdata, exp_status(1'b0, 1'b0, 1'b0, 1'b0));
    // random enable values read back
    for (int i = 0; i < 8; i++) begin
      s = xs(s);
      en_model = s[7:0];
      acc(1'b0, 1'b1, CLDS_ADDR_ENABLE, en_model);
      acc(1'b1, 1'b0, CLDS_ADDR_ENABLE, 8'h00);
      check(rdata, en_model);
    end
    // both events on; detect and lock rise
    s = xs(s);
    en_model = s[7:0] | 8'h03;
    acc(1'b0, 1'b1, CLDS_ADDR_ENABLE, en_model);
    sd = 1'b1;
    lk = 1'b1;
    idle(5);
    acc(1'b1, 1'b0, CLDS_ADDR_STATUS, 8'h00);
    check(rdata, exp_status(1'b1, 1'b1, 1'b1, 1'b1));
    acc(1'b1, 1'b0, CLDS_ADDR_STATUS, 8'h00);
    check(rdata, exp_status(1'b1, 1'b1, 1'b0, 1'b0));
    // lock lost: a fall sets nothing
    lk = 1'b0;
    idle(5);
    acc(1'b1, 1'b0, CLDS_ADDR_STATUS, 8'h00);
    check(rdata, exp_status(1'b1, 1'b0, 1'b0, 1'b0));
    // lock regained, then both pins drop before the read
    lk = 1'b1;
    idle(5);
    sd = 1'b0;
    lk = 1'b0;
    idle(5);
    acc(1'b1, 1'b0, CLDS_ADDR_STATUS, 8'h00);
    check(rdata, exp_status(1'b0, 1'b0, 1'b1, 1'b1));
    // both events off
    s = xs(s);
    en_model = s[7:0] & 8'hFC;
    acc(1'b0, 1'b1, CLDS_ADDR_ENABLE, en_model);
    acc(1'b1, 1'b0, CLDS_ADDR_ENABLE, 8'h00);
    check(rdata, en_model);
    acc(1'b1, 1'b0, CLDS_ADDR_STATUS, 8'h00);
    check(rdata, exp_status(1'b0, 1'b0, 1'b0, 1'b0));
    sd = 1'b1;
    lk = 1'b1;
    idle(4);
    acc(1'b1, 1'b0, CLDS_ADDR_STATUS, 8'h00);
    check(rdata, exp_status(1'b1, 1'b1, 1'b0, 1'b0));
    summarize();
  end
  // watchdog
  initial begin
    #100000;
    miscompares += 1;
    summarize();
  end
endmodule
